// *** hw/cfwsh_handler.sv ***
// Command handler for write-defaults and set-live field packets.
// Assumes deframed bytes from preamble to last payload byte, CRC result on last,
// and a same-clock field table answering o_chk_entry combinationally.

// How it works
// - A write-defaults packet has type 5746h, length 1+4 per field, a count byte then id/value pairs.
// - Accepted write-defaults values go only to the nonvolatile strobe, never to the live strobe.
// - Write-defaults entries naming calibration or algorithm fields are not stored.
// - If any write-defaults field is stored, a positive response lists exactly those ids.
// - If any write-defaults field fails, an error response follows, possibly after a positive one.
// - A write-defaults value outside its field's range counts as failed.
// - The write-defaults positive response has type 5746h, length 1+2 per field, count then ids.
// - A set-live packet has type 5346h, length 1+4 per field, a count byte then id/value pairs.
// - Accepted set-live values go at once to the live strobe only.
// - Set-live entries naming calibration or algorithm fields are not applied.
// - If any set-live field is applied, a positive response lists exactly those ids.
// - If any set-live field fails, an error response follows, possibly after a positive one.
// - A set-live value outside its field's range counts as failed.
// - The set-live positive response has type 5346h, length 1+2 per field, count then ids.
// - An orientation value outside the 24 legal codes is refused and leaves the field alone.
// - A live baud change is applied before the response is sent, so the response uses the new rate.
module cfwsh_handler (
    input wire logic i_mclk,
    input wire logic i_rst_b,
    input wire cfwsh_pkg::cfwsh_rx_t i_rx,
    output logic o_rx_ready,
    output cfwsh_pkg::cfwsh_entry_t o_chk_entry,
    input wire logic i_chk_config,
    input wire logic i_chk_in_range,
    output cfwsh_pkg::cfwsh_wr_t o_wr,
    output logic o_tx_valid,
    output logic [7:0] o_tx_data,
    output logic o_tx_last,
    input wire logic i_tx_ready
);

    typedef enum logic [3:0] {
        ST_PRE0, ST_PRE1, ST_TYP0, ST_TYP1, ST_LEN, ST_CNT, ST_BODY, ST_DROP,
        ST_PROC, ST_TX_POS, ST_TX_ERR
    } cfwsh_state_t;

    cfwsh_state_t state;
    cfwsh_state_t next_state;
    cfwsh_pkg::cfwsh_entry_t ent [cfwsh_pkg::MAX_FIELDS];
    logic [15:0] cmd_type;
    logic [7:0] len;
    logic [7:0] count;
    logic [5:0] bcnt;
    logic [3:0] pidx;
    logic [3:0] acc;
    logic err_any;
    logic bad;
    logic [5:0] tx_idx;

    // ==========================================
    // Decode
    wire rx_fire = i_rx.valid && o_rx_ready;
    wire [15:0] typ_word = {cmd_type[7:0], i_rx.data};
    wire typ_known = (typ_word == cfwsh_pkg::TYPE_WRITE_DEFAULTS) || (typ_word == cfwsh_pkg::TYPE_SET_LIVE);
    wire is_wd = (cmd_type == cfwsh_pkg::TYPE_WRITE_DEFAULTS);
    wire [7:0] want_len = 8'((9'(i_rx.data) << 2) + 9'h001);
    wire len_bad = (len != want_len) || (i_rx.data > cfwsh_pkg::MAX_FIELDS_B);
    wire [5:0] body_bytes = 6'(count << 2);
    wire [2:0] wr_idx = bcnt[4:2];
    wire body_over = (bcnt >= body_bytes);
    wire end_bad = bad || body_over || ((bcnt + 6'h01) != body_bytes);

    function automatic logic orient_legal(input logic [15:0] v);
        logic hit;
        hit = 1'b0;
        for (int k = 0; k < cfwsh_pkg::ORIENT_COUNT; k++) begin
            if (cfwsh_pkg::ORIENT_OK[k] == v) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction

    // Field check, one entry per cycle
    assign o_chk_entry = ent[pidx[2:0]];
    wire orient_ok = (o_chk_entry.id != cfwsh_pkg::ORIENT_ID) || orient_legal(o_chk_entry.value);
    wire accept = i_chk_config && i_chk_in_range && orient_ok;
    wire proc_done = (pidx == 4'(count - 8'h01)) || (count == 8'h00);

    // ==========================================
    // Response byte selection
    wire [5:0] id_off = tx_idx - cfwsh_pkg::HDR_BYTES;
    wire [15:0] id_word = ent[id_off[3:1]].id;
    wire [7:0] pos_len = 8'({acc, 1'b0} + 5'h01);
    wire [5:0] tx_n = (state == ST_TX_POS) ? 6'(cfwsh_pkg::HDR_BYTES + {acc, 1'b0}) : cfwsh_pkg::ERR_BYTES;
    wire [7:0] pos_byte = (tx_idx == 6'h02) ? cmd_type[15:8] :
                          (tx_idx == 6'h03) ? cmd_type[7:0] :
                          (tx_idx == 6'h04) ? pos_len :
                          (tx_idx == 6'h05) ? 8'(acc) :
                          (id_off[0] ? id_word[7:0] : id_word[15:8]);
    wire [7:0] err_byte = (tx_idx == 6'h02) ? cfwsh_pkg::TYPE_ERROR[15:8] :
                          (tx_idx == 6'h03) ? cfwsh_pkg::TYPE_ERROR[7:0] :
                          (tx_idx == 6'h04) ? cfwsh_pkg::ERR_LEN :
                          (tx_idx == 6'h05) ? cmd_type[15:8] : cmd_type[7:0];
    wire [7:0] next_byte = (tx_idx < 6'h02) ? cfwsh_pkg::PREAMBLE_BYTE :
                           (state == ST_TX_POS) ? pos_byte : err_byte;
    wire tx_adv = !o_tx_valid || i_tx_ready;
    wire tx_more = tx_idx < tx_n;
    wire tx_done = tx_adv && !tx_more;

    assign o_rx_ready = (state <= ST_DROP);

    // ==========================================
    // Next state
    always_comb begin
        next_state = state;
        unique case (state)
            ST_PRE0: if (rx_fire) next_state = i_rx.last ? ST_PRE0 :
                (i_rx.data == cfwsh_pkg::PREAMBLE_BYTE) ? ST_PRE1 : ST_DROP;
            ST_PRE1: if (rx_fire) next_state = i_rx.last ? ST_PRE0 :
                (i_rx.data == cfwsh_pkg::PREAMBLE_BYTE) ? ST_TYP0 : ST_DROP;
            ST_TYP0: if (rx_fire) next_state = i_rx.last ? ST_PRE0 : ST_TYP1;
            ST_TYP1: if (rx_fire) next_state = i_rx.last ? ST_PRE0 : (typ_known ? ST_LEN : ST_DROP);
            ST_LEN: if (rx_fire) next_state = i_rx.last ? ST_PRE0 : ST_CNT;
            ST_CNT: if (rx_fire) next_state = !i_rx.last ? ST_BODY :
                (i_rx.crc_ok && len_bad) ? ST_TX_ERR : ST_PRE0;
            ST_BODY: if (rx_fire && i_rx.last) next_state = !i_rx.crc_ok ? ST_PRE0 :
                end_bad ? ST_TX_ERR : ST_PROC;
            ST_DROP: if (rx_fire && i_rx.last) next_state = ST_PRE0;
            ST_PROC: if (proc_done) next_state = ((acc != 4'h0) || (accept && count != 8'h00)) ? ST_TX_POS :
                (err_any || !accept) ? ST_TX_ERR : ST_PRE0;
            ST_TX_POS: if (tx_done) next_state = err_any ? ST_TX_ERR : ST_PRE0;
            ST_TX_ERR: if (tx_done) next_state = ST_PRE0;
        endcase
    end

    // ==========================================
    // Receive and process
    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            state <= ST_PRE0;
            cmd_type <= 16'h0000;
            len <= 8'h00;
            count <= 8'h00;
            bcnt <= 6'h00;
            pidx <= 4'h0;
            acc <= 4'h0;
            err_any <= 1'b0;
            bad <= 1'b0;
        end else begin
            state <= next_state;
            if (rx_fire && (state == ST_TYP0 || state == ST_TYP1)) begin
                cmd_type <= typ_word;
            end
            if (rx_fire && state == ST_LEN) begin
                len <= i_rx.data;
            end
            if (rx_fire && state == ST_CNT) begin
                count <= i_rx.data;
                bad <= len_bad;
                bcnt <= 6'h00;
                pidx <= 4'h0;
                acc <= 4'h0;
                err_any <= 1'b0;
            end
            if (rx_fire && state == ST_BODY && !body_over) begin
                bcnt <= bcnt + 6'h01;
            end
            if (state == ST_PROC) begin
                pidx <= pidx + 4'h1;
                if (count != 8'h00 && accept) begin
                    acc <= acc + 4'h1;
                end
                if (count != 8'h00 && !accept) begin
                    err_any <= 1'b1;
                end
            end
        end
    end

    // Entry store: body bytes in, then compacted to the accepted ids
    always_ff @(posedge i_mclk) begin
        if (rx_fire && state == ST_BODY && !body_over && !bad) begin
            unique case (bcnt[1:0])
                2'h0: ent[wr_idx].id[15:8] <= i_rx.data;
                2'h1: ent[wr_idx].id[7:0] <= i_rx.data;
                2'h2: ent[wr_idx].value[15:8] <= i_rx.data;
                2'h3: ent[wr_idx].value[7:0] <= i_rx.data;
            endcase
        end else if (state == ST_PROC && accept && count != 8'h00) begin
            ent[acc[2:0]].id <= o_chk_entry.id;
        end
    end

    // Field update strobes; live update lands before the response
    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            o_wr <= '0;
        end else begin
            o_wr.nv <= (state == ST_PROC) && accept && is_wd && count != 8'h00;
            o_wr.live <= (state == ST_PROC) && accept && !is_wd && count != 8'h00;
            o_wr.id <= o_chk_entry.id;
            o_wr.value <= o_chk_entry.value;
        end
    end

    // ==========================================
    // Transmit
    always_ff @(posedge i_mclk) begin
        if (!i_rst_b) begin
            tx_idx <= 6'h00;
            o_tx_valid <= 1'b0;
            o_tx_data <= 8'h00;
            o_tx_last <= 1'b0;
        end else if ((state == ST_TX_POS || state == ST_TX_ERR) && tx_adv) begin
            o_tx_valid <= tx_more;
            o_tx_last <= tx_more && (tx_idx == tx_n - 6'h01);
            if (tx_more) begin
                o_tx_data <= next_byte;
            end
            tx_idx <= tx_more ? tx_idx + 6'h01 : 6'h00;
        end
    end

    // ==========================================
    // Checks
    strobe_excl_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        !(o_wr.nv && o_wr.live)) else $error("both update strobes high");
    nv_only_wd_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        o_wr.nv |-> cmd_type == cfwsh_pkg::TYPE_WRITE_DEFAULTS) else $error("nv write outside write-defaults");
    live_only_sl_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        o_wr.live |-> cmd_type == cfwsh_pkg::TYPE_SET_LIVE) else $error("live write outside set-live");
    cal_refused_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        (o_wr.nv || o_wr.live) |-> $past(i_chk_config) && $past(i_chk_in_range)) else $error("refused field updated");
    orient_guard_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        (o_wr.nv || o_wr.live) && o_wr.id == cfwsh_pkg::ORIENT_ID |-> orient_legal(o_wr.value))
        else $error("illegal orientation stored");
    preamble_first_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        $rose(o_tx_valid) |-> o_tx_data == cfwsh_pkg::PREAMBLE_BYTE) else $error("response without preamble");
    pos_len_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        state == ST_TX_POS && tx_idx == 6'h05 && o_tx_valid |-> o_tx_data == pos_len) else $error("bad response length");
    err_follows_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        state == ST_TX_POS && tx_done |=> (state == ST_TX_ERR) == err_any) else $error("error response mismatch");
    crc_drop_a: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
        state == ST_BODY && rx_fire && i_rx.last && !i_rx.crc_ok |=> state == ST_PRE0 ##1 !o_tx_valid)
        else $error("bad CRC packet answered");
    cov_pos_c: cover property (@(posedge i_mclk) state == ST_TX_POS && tx_done && !err_any);
    cov_both_c: cover property (@(posedge i_mclk) state == ST_TX_POS ##[1:100] state == ST_TX_ERR);
    cov_live_c: cover property (@(posedge i_mclk) o_wr.live);

endmodule

// *** include/cfwsh_pkg.sv ***
// Constants and carriers for the field write/set command handler.
// Assumes a deframer that strips the CRC and flags it on the last payload byte.
package cfwsh_pkg;

    // ==========================================
    // Packet constants
    localparam logic [7:0] PREAMBLE_BYTE = 8'h55;
    localparam logic [15:0] TYPE_WRITE_DEFAULTS = 16'h5746;
    localparam logic [15:0] TYPE_SET_LIVE = 16'h5346;
    localparam logic [15:0] TYPE_ERROR = 16'h4552;
    localparam logic [7:0] ERR_LEN = 8'h02;
    localparam int MAX_FIELDS = 8;
    localparam logic [7:0] MAX_FIELDS_B = 8'h08;
    localparam logic [5:0] HDR_BYTES = 6'h06;
    localparam logic [5:0] ERR_BYTES = 6'h07;

    // ==========================================
    // Orientation field
    localparam logic [15:0] ORIENT_ID = 16'h0007;
    localparam int ORIENT_COUNT = 24;
    localparam logic [15:0] ORIENT_OK [ORIENT_COUNT] = '{
        16'h0000, 16'h0009, 16'h0023, 16'h002A, 16'h0041, 16'h0048,
        16'h0062, 16'h006B, 16'h0085, 16'h008C, 16'h0092, 16'h009B,
        16'h00C4, 16'h00CD, 16'h00D3, 16'h00DA, 16'h0111, 16'h0118,
        16'h0124, 16'h012D, 16'h0150, 16'h0159, 16'h0165, 16'h016C};

    // ==========================================
    // Carriers
    typedef struct packed {
        logic valid;
        logic [7:0] data;
        logic last;
        logic crc_ok;
    } cfwsh_rx_t;

    typedef struct packed {
        logic [15:0] id;
        logic [15:0] value;
    } cfwsh_entry_t;

    typedef struct packed {
        logic nv;
        logic live;
        logic [15:0] id;
        logic [15:0] value;
    } cfwsh_wr_t;

endpackage

// *** bench/cfwsh_field_table.sv ***
// Field table model standing beside the handler's entry check port.
// Assumes one entry is presented at a time and answered in the same cycle.
module cfwsh_field_table (
    input wire cfwsh_pkg::cfwsh_entry_t i_entry,
    output logic o_config,
    output logic o_in_range
);
    timeunit 1ns;
    timeprecision 100ps;
    // ==========================================
    // Field classes
    // Ids 0100h and up stand for calibration and algorithm fields
    assign o_config = (i_entry.id[15:8] == 8'h00);
    // All-ones is out of range for every field, so one value serves all
    assign o_in_range = (i_entry.value != 16'hFFFF);
endmodule

// *** bench/config_field_write_set_handler_tb.sv ***
// Self-checking bench for the field write/set command handler.
// Assumes the package, the handler and the field table model compile first.
module config_field_write_set_handler_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic i_mclk;
    logic i_rst_b;
    cfwsh_pkg::cfwsh_rx_t i_rx;
    logic o_rx_ready;
    cfwsh_pkg::cfwsh_entry_t o_chk_entry;
    logic chk_config;
    logic chk_in_range;
    cfwsh_pkg::cfwsh_wr_t o_wr;
    logic o_tx_valid;
    logic [7:0] o_tx_data;
    logic o_tx_last;
    logic i_tx_ready;
    logic [1:0] stall_cnt;
    int err_total;
    int checks;
    int len_adj;
    logic [7:0] tx_q[$];
    logic last_q[$];
    logic [31:0] nv_q[$];
    logic [31:0] live_q[$];
    cfwsh_pkg::cfwsh_entry_t ents[$];

    cfwsh_handler cfwsh_handler_i (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_rx(i_rx), .o_rx_ready(o_rx_ready),
        .o_chk_entry(o_chk_entry), .i_chk_config(chk_config), .i_chk_in_range(chk_in_range), .o_wr(o_wr),
        .o_tx_valid(o_tx_valid), .o_tx_data(o_tx_data), .o_tx_last(o_tx_last), .i_tx_ready(i_tx_ready));
    cfwsh_field_table cfwsh_field_table_i (.i_entry(o_chk_entry), .o_config(chk_config),
        .o_in_range(chk_in_range));

    // ==========================================
    // Clock, sink stall and capture
    initial begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end
    // Sink stalls one cycle in four so held bytes get exercised
    always @(posedge i_mclk) begin
        #1;
        stall_cnt = stall_cnt + 2'd1;
        i_tx_ready = (stall_cnt != 2'd3);
    end
    always @(posedge i_mclk) begin
        if (o_tx_valid === 1'b1 && i_tx_ready === 1'b1) begin
            tx_q.push_back(o_tx_data);
            last_q.push_back(o_tx_last);
        end
        if (o_wr.nv === 1'b1)
            nv_q.push_back({o_wr.id, o_wr.value});
        if (o_wr.live === 1'b1)
            live_q.push_back({o_wr.id, o_wr.value});
    end

    // ==========================================
    // Shared tasks
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Only sent while idle, where the receiver takes a byte every edge
    task automatic send_byte(input logic [7:0] b, input logic l, input logic ok);
        i_rx = '{valid: 1'b1, data: b, last: l, crc_ok: ok};
        @(posedge i_mclk);
        #1;
    endtask
    task automatic run_cmd(input logic [15:0] ty, input logic ok);
        logic [7:0] exp[$];
        cfwsh_pkg::cfwsh_entry_t acc[$];
        logic good;
        logic fail;
        logic wd;
        int w;
        int pos_n;
        tx_q.delete();
        last_q.delete();
        nv_q.delete();
        live_q.delete();
        fail = 1'b0;
        wd = (ty == cfwsh_pkg::TYPE_WRITE_DEFAULTS);
        exp = '{8'h55, 8'h55, ty[15:8], ty[7:0], 8'(1 + 4 * ents.size() + len_adj), 8'(ents.size())};
        foreach (exp[i])
            send_byte(exp[i], 1'b0, ok);
        foreach (ents[i]) begin
            send_byte(ents[i].id[15:8], 1'b0, ok);
            send_byte(ents[i].id[7:0], 1'b0, ok);
            send_byte(ents[i].value[15:8], 1'b0, ok);
            send_byte(ents[i].value[7:0], i == ents.size() - 1, ok);
        end
        i_rx = '0;
        // Look past the edge, so the next packet never starts on the edge itself
        for (w = 0; w < 3 || (w < 400 && !(o_rx_ready === 1'b1 && o_tx_valid === 1'b0)); w++) begin
            @(posedge i_mclk);
            #1;
        end
        if (w >= 400) begin
            err_total++;
            summarize();
        end
        foreach (ents[i]) begin
            good = ents[i].id[15:8] == 8'h00 && ents[i].value != 16'hFFFF;
            if (ents[i].id == cfwsh_pkg::ORIENT_ID)
                good = good && (ents[i].value inside {cfwsh_pkg::ORIENT_OK});
            if (good && ok && len_adj == 0)
                acc.push_back(ents[i]);
            fail = fail | (!good && ok) | (ok && len_adj != 0);
        end
        exp.delete();
        if (acc.size() > 0)
            exp = '{8'h55, 8'h55, ty[15:8], ty[7:0], 8'(1 + 2 * acc.size()), 8'(acc.size())};
        foreach (acc[i])
            exp = {exp, acc[i].id[15:8], acc[i].id[7:0]};
        pos_n = exp.size();
        if (fail)
            exp = {exp, 8'h55, 8'h55, cfwsh_pkg::TYPE_ERROR[15:8], cfwsh_pkg::TYPE_ERROR[7:0],
                cfwsh_pkg::ERR_LEN, ty[15:8], ty[7:0]};
        chk8("tx count", 8'(exp.size()), 8'(tx_q.size()));
        foreach (exp[i])
            chk8("tx byte", exp[i], i < tx_q.size() ? tx_q[i] : 8'h00);
        foreach (exp[i])
            chk8("tx last", 8'(i == pos_n - 1 || i == exp.size() - 1), i < last_q.size() ? 8'(last_q[i]) : 8'h00);
        chk8("nv count", wd ? 8'(acc.size()) : 8'h00, 8'(nv_q.size()));
        chk8("live count", wd ? 8'h00 : 8'(acc.size()), 8'(live_q.size()));
        foreach (acc[i])
            chk32("write", acc[i], wd ? nv_q[i] : live_q[i]);
    endtask

    // ==========================================
    // Scenarios
    task automatic t_reset_idle();
        chk8("rx ready idle", 8'h01, 8'(o_rx_ready));
        chk8("tx valid idle", 8'h00, 8'(o_tx_valid));
        $display("test reset_idle done");
    endtask
    task automatic t_write_ok();
        ents = '{'{16'h0001, 16'h0010}, '{cfwsh_pkg::ORIENT_ID, 16'h0009}};
        run_cmd(cfwsh_pkg::TYPE_WRITE_DEFAULTS, 1'b1);
        $display("test write_ok done");
    endtask
    task automatic t_set_mixed();
        ents = '{'{16'h0002, 16'h0005}, '{16'h0103, 16'h0001}, '{16'h0004, 16'hFFFF},
            '{cfwsh_pkg::ORIENT_ID, 16'h0001}, '{cfwsh_pkg::ORIENT_ID, 16'h016C}};
        run_cmd(cfwsh_pkg::TYPE_SET_LIVE, 1'b1);
        $display("test set_mixed done");
    endtask
    task automatic t_write_fail();
        ents = '{'{16'h0105, 16'h0000}, '{16'h0006, 16'hFFFF}};
        run_cmd(cfwsh_pkg::TYPE_WRITE_DEFAULTS, 1'b1);
        $display("test write_fail done");
    endtask
    task automatic t_bad_crc();
        ents = '{'{16'h0001, 16'h0002}};
        run_cmd(cfwsh_pkg::TYPE_SET_LIVE, 1'b0);
        $display("test bad_crc done");
    endtask
    // Length byte that disagrees with the count: error only, nothing stored
    task automatic t_bad_len();
        ents = '{'{16'h0001, 16'h0002}};
        len_adj = 4;
        run_cmd(cfwsh_pkg::TYPE_WRITE_DEFAULTS, 1'b1);
        len_adj = 0;
        $display("test bad_len done");
    endtask
    task automatic t_set_full();
        ents.delete();
        for (int i = 0; i < cfwsh_pkg::MAX_FIELDS; i++)
            ents.push_back('{16'(i + 1), 16'(16 * i)});
        run_cmd(cfwsh_pkg::TYPE_SET_LIVE, 1'b1);
        $display("test set_full done");
    endtask

    initial begin
        i_rst_b = 1'b0;
        i_rx = '0;
        i_tx_ready = 1'b0;
        stall_cnt = 2'd0;
        err_total = 0;
        checks = 0;
        len_adj = 0;
        repeat (8) @(posedge i_mclk);
        #1;
        i_rst_b = 1'b1;
        t_reset_idle();
        t_write_ok();
        t_set_mixed();
        t_write_fail();
        t_bad_crc();
        t_bad_len();
        t_set_full();
        summarize();
    end
endmodule
